//--- src/utsf_pkg.sv
package utsf_pkg;

    // register byte offsets
    localparam logic [7:0] UTSF_STATUS_OFF = 8'h00;
    localparam logic [7:0] UTSF_HOSTFLAG_OFF = 8'h04;
    localparam logic [7:0] UTSF_FLAGCLR_OFF = 8'h08;
    localparam logic [7:0] UTSF_IRQSTAT_OFF = 8'h0C;
    localparam logic [7:0] UTSF_IRQCLR_OFF = 8'h10;
    localparam logic [7:0] UTSF_IRQEN_OFF = 8'h14;
    localparam logic [7:0] UTSF_CTRL_OFF = 8'h18;
    localparam logic [7:0] UTSF_EP0IN_OFF = 8'h1C;
    localparam logic [7:0] UTSF_EP0OUT_OFF = 8'h20;

    // status field positions
    localparam int UTSF_FLAG_LSB = 0;
    localparam int UTSF_EP_LSB = 8;
    localparam int UTSF_VALID_BIT = 15;
    localparam int UTSF_COUNT_LSB = 16;

    // flag bits, one hot in the flag field
    localparam int UTSF_F_SETUP = 0;
    localparam int UTSF_F_IN = 1;
    localparam int UTSF_F_OUT = 2;
    localparam int UTSF_F_LPM = 3;
    localparam int UTSF_F_STALL = 4;

    // host flag bits
    localparam int UTSF_H_SETUP = 0;
    localparam int UTSF_H_IN = 1;
    localparam int UTSF_H_OUT = 2;
    localparam int UTSF_H_STALL = 3;

    // reset values
    localparam logic [31:0] UTSF_ZERO_RST = 32'h0000_0000;

    localparam logic [1:0] UTSF_RESP_OKAY = 2'h0;
    localparam logic [1:0] UTSF_RESP_SLVERR = 2'h2;

    // transaction kind reported by the engine
    typedef enum logic [2:0] {
        UTSF_EV_SETUP,
        UTSF_EV_IN,
        UTSF_EV_OUT,
        UTSF_EV_LPM,
        UTSF_EV_STALL
    } utsf_kind_t;

    // one completed transaction from the engine
    typedef struct packed {
        logic valid;
        utsf_kind_t kind;
        logic [3:0] ep;
    } utsf_event_t;

    // one queue entry
    typedef struct packed {
        logic [4:0] flags;
        logic [3:0] ep;
    } utsf_entry_t;

endpackage

//--- src/utsf_status_flags.sv
`timescale 1ns/100ps
module utsf_status_flags
    import utsf_pkg::*;
#(
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire utsf_event_t devEvent,
    input wire utsf_event_t hostEvent,
    input wire logic hostStalled,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic hostRole,
    output logic [31:0] ep0InCtrl,
    output logic [31:0] ep0OutCtrl,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // write channel capture

    logic awHeld_q, wHeld_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q;
    logic doWrite;
    logic wrStatus, wrFlagClr, wrIrqClr, wrIrqEn, wrCtrl, wrEp0In, wrEp0Out;
    logic wrHostFlag;

    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

    // address and data may arrive in either order
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= UTSF_ZERO_RST;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            // readies are flops, low from their handshake until bresp goes
            s_axi_awready <= s_axi_awready ? !s_axi_awvalid
                : !awHeld_q && (!s_axi_bvalid || s_axi_bready);
            s_axi_wready <= s_axi_wready ? !s_axi_wvalid
                : !wHeld_q && (!s_axi_bvalid || s_axi_bready);
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
            end else if (doWrite) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    // write decode, one strobe per register except read-only irq status
    always_comb begin
        wrStatus = 1'b0;
        wrFlagClr = 1'b0;
        wrHostFlag = 1'b0;
        wrIrqClr = 1'b0;
        wrIrqEn = 1'b0;
        wrCtrl = 1'b0;
        wrEp0In = 1'b0;
        wrEp0Out = 1'b0;
        if (!doWrite) begin
            wrStatus = 1'b0;
        end else if (awAddr_q == UTSF_STATUS_OFF) begin
            wrStatus = 1'b1;
        end else if (awAddr_q == UTSF_FLAGCLR_OFF) begin
            wrFlagClr = 1'b1;
        end else if (awAddr_q == UTSF_HOSTFLAG_OFF) begin
            wrHostFlag = 1'b1;
        end else if (awAddr_q == UTSF_IRQCLR_OFF) begin
            wrIrqClr = 1'b1;
        end else if (awAddr_q == UTSF_IRQEN_OFF) begin
            wrIrqEn = 1'b1;
        end else if (awAddr_q == UTSF_CTRL_OFF) begin
            wrCtrl = 1'b1;
        end else if (awAddr_q == UTSF_EP0IN_OFF) begin
            wrEp0In = 1'b1;
        end else if (awAddr_q == UTSF_EP0OUT_OFF) begin
            wrEp0Out = 1'b1;
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= UTSF_RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wrStatus || wrFlagClr || wrHostFlag || wrIrqClr
                || wrIrqEn || wrCtrl || wrEp0In || wrEp0Out)
                ? UTSF_RESP_OKAY : UTSF_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // device-role event queue

    utsf_entry_t mem [DEPTH];
    logic [AW:0] wrPtr_q, rdPtr_q;
    logic [AW:0] count;
    logic qEmpty, qFull, push, pop;
    utsf_entry_t newEntry, head;
    logic [4:0] headFlags_q;

    assign count = wrPtr_q - rdPtr_q;
    assign qEmpty = (count == '0);
    assign qFull = (count == (AW + 1)'(DEPTH));
    assign head = mem[rdPtr_q[AW-1:0]];
    // device events are dropped in host role and when full
    assign push = devEvent.valid && !hostRole && !qFull
        && newEntry.flags != 5'h00;
    // head leaves only once its flags were shown and are all cleared
    assign pop = !qEmpty && wrFlagClr && headFlags_q != 5'h00
        && ((headFlags_q & ~wData_q[4:0]) == 5'h00);

    // one-hot flag per transaction kind
    always_comb begin
        newEntry.flags = 5'h00;
        newEntry.ep = devEvent.ep;
        case (devEvent.kind)
            UTSF_EV_SETUP: newEntry.flags[UTSF_F_SETUP] = 1'b1;
            UTSF_EV_IN: newEntry.flags[UTSF_F_IN] = 1'b1;
            UTSF_EV_OUT: newEntry.flags[UTSF_F_OUT] = 1'b1;
            UTSF_EV_LPM: newEntry.flags[UTSF_F_LPM] = 1'b1;
            UTSF_EV_STALL: newEntry.flags[UTSF_F_STALL] = 1'b1;
            default: newEntry.flags = 5'h00;
        endcase
    end

    // storage array; entries are only written, never reset
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wrPtr_q[AW-1:0]] <= newEntry;
        end
    end

    // pointers; a flush empties everything at once
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else if (wrStatus) begin
            rdPtr_q <= wrPtr_q;
        end else begin
            if (push) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end

    // head flags held until software clears them, bit by bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            headFlags_q <= 5'h00;
        end else if (wrStatus) begin
            headFlags_q <= 5'h00;
        end else if (pop || (qEmpty && !push)) begin
            headFlags_q <= 5'h00;
        end else if (qEmpty && push) begin
            headFlags_q <= newEntry.flags;
        end else if (wrFlagClr) begin
            headFlags_q <= headFlags_q & ~wData_q[4:0];
        end else if (headFlags_q == 5'h00) begin
            headFlags_q <= head.flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // host-role flags, not queued

    logic [3:0] hostFlags_q;
    logic [3:0] hostSet;

    // a stall takes the place of the completion flag
    always_comb begin
        hostSet = 4'h0;
        if (hostEvent.valid && hostRole) begin
            if (hostStalled) begin
                hostSet[UTSF_H_STALL] = 1'b1;
            end else if (hostEvent.kind == UTSF_EV_SETUP) begin
                hostSet[UTSF_H_SETUP] = 1'b1;
            end else if (hostEvent.kind == UTSF_EV_IN) begin
                hostSet[UTSF_H_IN] = 1'b1;
            end else if (hostEvent.kind == UTSF_EV_OUT) begin
                hostSet[UTSF_H_OUT] = 1'b1;
            end
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hostFlags_q <= 4'h0;
        end else begin
            hostFlags_q <= (hostFlags_q
                & ~(wrHostFlag ? wData_q[3:0] : 4'h0)) | hostSet;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control and endpoint-0 registers

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hostRole <= 1'b0;
        end else if (wrCtrl) begin
            hostRole <= wData_q[0];
        end
    end

    // a queued setup cancels pending control transfers, over a write
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ep0InCtrl <= UTSF_ZERO_RST;
            ep0OutCtrl <= UTSF_ZERO_RST;
        end else if (push && newEntry.flags[UTSF_F_SETUP]) begin
            ep0InCtrl <= UTSF_ZERO_RST;
            ep0OutCtrl <= UTSF_ZERO_RST;
        end else begin
            if (wrEp0In) begin
                ep0InCtrl <= wData_q;
            end
            if (wrEp0Out) begin
                ep0OutCtrl <= wData_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky causes, clear register, enable register

    logic [1:0] irqStat_q, irqEn_q, irqSet;

    assign irqSet = {hostSet != 4'h0, push};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqStat_q <= 2'h0;
            irqEn_q <= 2'h0;
            irq <= 1'b0;
        end else begin
            irqStat_q <= (irqStat_q & ~(wrIrqClr ? wData_q[1:0] : 2'h0))
                | irqSet;
            if (wrIrqEn) begin
                irqEn_q <= wData_q[1:0];
            end
            irq <= |(irqStat_q & irqEn_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read channel

    logic [31:0] rdMux;
    logic rdOk;

    // status: head flags, head endpoint, valid, depth
    always_comb begin
        rdMux = UTSF_ZERO_RST;
        rdOk = 1'b1;
        if (s_axi_araddr == UTSF_STATUS_OFF) begin
            rdMux[UTSF_FLAG_LSB +: 5] = headFlags_q;
            rdMux[UTSF_EP_LSB +: 4] = qEmpty ? 4'h0 : head.ep;
            rdMux[UTSF_VALID_BIT] = !qEmpty;
            rdMux[UTSF_COUNT_LSB +: AW + 1] = count;
        end else if (s_axi_araddr == UTSF_HOSTFLAG_OFF) begin
            rdMux[3:0] = hostFlags_q;
        end else if (s_axi_araddr == UTSF_FLAGCLR_OFF) begin
            rdMux = UTSF_ZERO_RST;
        end else if (s_axi_araddr == UTSF_IRQSTAT_OFF) begin
            rdMux[1:0] = irqStat_q;
        end else if (s_axi_araddr == UTSF_IRQCLR_OFF) begin
            rdMux = UTSF_ZERO_RST;
        end else if (s_axi_araddr == UTSF_IRQEN_OFF) begin
            rdMux[1:0] = irqEn_q;
        end else if (s_axi_araddr == UTSF_CTRL_OFF) begin
            rdMux[0] = hostRole;
        end else if (s_axi_araddr == UTSF_EP0IN_OFF) begin
            rdMux = ep0InCtrl;
        end else if (s_axi_araddr == UTSF_EP0OUT_OFF) begin
            rdMux = ep0OutCtrl;
        end else begin
            rdOk = 1'b0;
        end
    end

    // one read at a time; arready is a flop, low until rdata is taken
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= UTSF_ZERO_RST;
            s_axi_rresp <= UTSF_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arready ? !s_axi_arvalid
                : (!s_axi_rvalid || s_axi_rready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdOk ? UTSF_RESP_OKAY : UTSF_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_setup_cancels_ep0: assert property (@(posedge sys_clk) disable iff (rst)
        push && devEvent.kind == UTSF_EV_SETUP |=> ep0InCtrl == 32'h0
        && ep0OutCtrl == 32'h0) else $error("ep0 not cleared by setup");
    a_flush_empties: assert property (@(posedge sys_clk) disable iff (rst)
        wrStatus |=> qEmpty) else $error("status write did not flush");
    a_host_stall_only: assert property (@(posedge sys_clk) disable iff (rst)
        hostSet[UTSF_H_STALL] |-> hostSet[2:0] == 3'h0)
        else $error("stall with completion flag");
    a_flags_sticky: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(hostFlags_q[UTSF_H_STALL]) |-> $past(wrHostFlag))
        else $error("host flag dropped without clear");
    a_order_kept: assert property (@(posedge sys_clk) disable iff (rst)
        push && qEmpty && !wrStatus |=> headFlags_q == $past(newEntry.flags))
        else $error("first entry not at head");
    a_pop_on_clear: assert property (@(posedge sys_clk) disable iff (rst)
        pop |-> wrFlagClr && !qEmpty) else $error("pop without clear");
    a_advance_moves: assert property (@(posedge sys_clk) disable iff (rst)
        pop && !wrStatus |=> rdPtr_q == $past(rdPtr_q) + 1'b1)
        else $error("queue did not advance");
    a_in_flag_cause: assert property (@(posedge sys_clk) disable iff (rst)
        push |-> $onehot(newEntry.flags)
        && newEntry.flags[UTSF_F_IN] == (devEvent.kind == UTSF_EV_IN))
        else $error("in flag without in event");
    a_host_no_queue: assert property (@(posedge sys_clk) disable iff (rst)
        hostRole |-> !push) else $error("queued in host role");

endmodule

//--- verification/utsf_link_model.sv
`timescale 1ns/100ps
// stand-in for the engine: finished transactions arrive as one-cycle pulses
module utsf_link_model
    import utsf_pkg::*;
(
    input wire logic sys_clk,
    output utsf_event_t devEvent,
    output utsf_event_t hostEvent,
    output logic hostStalled
);
    initial begin
        devEvent = '0;
        hostEvent = '0;
        hostStalled = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // device role: a stall is reported as a transaction kind of its own
    task automatic dev_pulse(input utsf_kind_t kind, input logic [3:0] ep);
        @(posedge sys_clk);
        devEvent <= '{1'b1, kind, ep};
        @(posedge sys_clk);
        devEvent.valid <= 1'b0;
        devEvent.ep <= ~ep; // idle payload is junk, never to be trusted
    endtask
    // host role: the stall qualifier travels with the completion pulse
    task automatic host_pulse(input utsf_kind_t kind, input logic stall);
        @(posedge sys_clk);
        hostEvent <= '{1'b1, kind, 4'h0};
        hostStalled <= stall;
        @(posedge sys_clk);
        hostEvent.valid <= 1'b0;
        hostStalled <= ~stall;
    endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/100ps
module testbench
    import utsf_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, hostRole, irq, hostStalled;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, ep0InCtrl, ep0OutCtrl, rd, ex;
    utsf_event_t devEvent, hostEvent;
    int errorCnt = 0;
    int nTests = 0;
    logic [4:0] fl [4] = '{5'h02, 5'h04, 5'h08, 5'h10};
    logic [3:0] epn [4] = '{4'h3, 4'h5, 4'h2, 4'h1};
    utsf_kind_t kd [4] = '{UTSF_EV_IN, UTSF_EV_OUT, UTSF_EV_LPM, UTSF_EV_STALL};
    logic [7:0] offs [7] = '{UTSF_STATUS_OFF, UTSF_HOSTFLAG_OFF,
        UTSF_IRQSTAT_OFF, UTSF_IRQEN_OFF, UTSF_CTRL_OFF, UTSF_EP0IN_OFF,
        UTSF_EP0OUT_OFF};

    always #5 sys_clk = ~sys_clk;

    utsf_status_flags u_dut (
        .sys_clk, .rst, .devEvent, .hostEvent, .hostStalled,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .hostRole, .ep0InCtrl, .ep0OutCtrl, .irq
    );
    utsf_link_model u_link (.sys_clk, .devEvent, .hostEvent, .hostStalled);

    ////////////////////////////////////////////////////////////////////
    // verdict and bookkeeping
    task automatic wrapUp;
        $display("comparisons %0d mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic hang;
        errorCnt++;
        $display("wrong value handshake expected answer seen none");
        wrapUp();
    endtask
    task automatic check(input string nm, input logic [31:0] seen, exp);
        nTests++;
        if (seen !== exp) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // head entry as software should see it, queue known to be non-empty
    function automatic logic [31:0] st(logic [4:0] f, logic [3:0] e,
        logic [3:0] c);
        return {12'h000, c, 1'b1, 3'h0, e, 3'h0, f};
    endfunction
    // lets pulses land; ports are then sampled well away from any edge
    task automatic idle;
        repeat (3) @(negedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////
    // bus master: ready is looked at mid-cycle, the hand-off is the edge
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic awOk, wOk;
        awOk = 1'b0;
        wOk = 1'b0;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; !(awOk && wOk); n++) begin
            if (n == 50) hang();
            @(negedge sys_clk);
            awOk = awOk | s_axi_awready;
            wOk = wOk | s_axi_wready;
            @(posedge sys_clk);
            if (awOk) s_axi_awvalid <= 1'b0;
            if (wOk) s_axi_wvalid <= 1'b0;
        end
        for (n = 0; s_axi_bvalid !== 1'b1; n++) begin
            if (n == 50) hang();
            @(negedge sys_clk);
        end
        rsp = s_axi_bresp;
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        int n;
        logic ok;
        ok = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; !ok; n++) begin
            if (n == 50) hang();
            @(negedge sys_clk);
            ok = s_axi_arready;
            @(posedge sys_clk);
            if (ok) s_axi_arvalid <= 1'b0;
        end
        for (n = 0; s_axi_rvalid !== 1'b1; n++) begin
            if (n == 50) hang();
            @(negedge sys_clk);
        end
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    // watchdog so a stuck handshake still reaches the verdict
    initial begin
        repeat (20000) @(posedge sys_clk);
        hang();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        foreach (offs[i]) begin
            rd_reg(offs[i]);
            check("reset value", rd, UTSF_ZERO_RST);
        end
        check("reset ports", {30'h0, irq, hostRole}, UTSF_ZERO_RST);
        // holes in the map answer with an error and no data
        rd_reg(8'h40);
        check("unmapped read", rd, UTSF_ZERO_RST);
        check("unmapped rresp", {30'h0, rsp}, {30'h0, UTSF_RESP_SLVERR});
        wr_reg(8'h40, 32'hFFFF_FFFF);
        check("unmapped bresp", {30'h0, rsp}, {30'h0, UTSF_RESP_SLVERR});
        wr_reg(UTSF_IRQEN_OFF, 32'h0000_0001);
        wr_reg(UTSF_EP0IN_OFF, 32'hA5A5_0001);
        wr_reg(UTSF_EP0OUT_OFF, 32'h5A5A_0002);
        // four kinds back to back, each on its own endpoint
        foreach (kd[i]) u_link.dev_pulse(kd[i], epn[i]);
        idle();
        check("irq raised", {31'h0, irq}, 32'h0000_0001);
        // clearing bits other than the head's must not advance
        wr_reg(UTSF_FLAGCLR_OFF, 32'h0000_001D);
        foreach (kd[i]) begin
            ex = st(fl[i], epn[i], 4'(4 - i));
            rd_reg(UTSF_STATUS_OFF);
            check("queue head", rd, ex);
            rd_reg(UTSF_STATUS_OFF);
            check("head held", rd, ex);
            wr_reg(UTSF_FLAGCLR_OFF, {27'h0, fl[i]});
            idle();
        end
        rd_reg(UTSF_STATUS_OFF);
        check("queue drained", rd, UTSF_ZERO_RST);
        check("ep0 in kept", ep0InCtrl, 32'hA5A5_0001);
        check("ep0 out kept", ep0OutCtrl, 32'h5A5A_0002);
        // interrupt cleared, then masked while an event is pending
        wr_reg(UTSF_IRQCLR_OFF, 32'h0000_0001);
        idle();
        check("irq cleared", {31'h0, irq}, UTSF_ZERO_RST);
        wr_reg(UTSF_IRQEN_OFF, UTSF_ZERO_RST);
        u_link.dev_pulse(UTSF_EV_SETUP, 4'h0);
        u_link.dev_pulse(UTSF_EV_OUT, 4'h7);
        idle();
        check("irq masked", {31'h0, irq}, UTSF_ZERO_RST);
        rd_reg(UTSF_IRQSTAT_OFF);
        check("irq pending", rd, 32'h0000_0001);
        check("ep0 in cancelled", ep0InCtrl, UTSF_ZERO_RST);
        check("ep0 out cancelled", ep0OutCtrl, UTSF_ZERO_RST);
        rd_reg(UTSF_STATUS_OFF);
        check("setup head", rd, st(5'h01, 4'h0, 4'h2));
        // any value written to status empties the queue
        wr_reg(UTSF_STATUS_OFF, 32'h1234_5678);
        idle();
        rd_reg(UTSF_STATUS_OFF);
        check("flushed", rd, UTSF_ZERO_RST);
        // a full queue drops the ninth event and keeps the first at its head
        repeat (9) u_link.dev_pulse(UTSF_EV_OUT, 4'h4);
        idle();
        rd_reg(UTSF_STATUS_OFF);
        check("full queue", rd, st(5'h04, 4'h4, 4'h8));
        wr_reg(UTSF_STATUS_OFF, UTSF_ZERO_RST);
        idle();
        rd_reg(UTSF_STATUS_OFF);
        check("full flushed", rd, UTSF_ZERO_RST);
        // host role: a stall stands in for the completion flag
        wr_reg(UTSF_CTRL_OFF, 32'h0000_0001);
        check("host role", {31'h0, hostRole}, 32'h0000_0001);
        for (int k = 0; k < 3; k++) begin
            u_link.host_pulse(utsf_kind_t'(k), 1'b1);
            idle();
            rd_reg(UTSF_HOSTFLAG_OFF);
            check("host stall", rd, 32'h0000_0008);
            // stall cleared before the next transaction is enabled
            wr_reg(UTSF_HOSTFLAG_OFF, 32'h0000_000F);
            u_link.host_pulse(utsf_kind_t'(k), 1'b0);
            idle();
            rd_reg(UTSF_HOSTFLAG_OFF);
            check("host done", rd, 32'h0000_0001 << k);
            wr_reg(UTSF_HOSTFLAG_OFF, 32'h0000_000F);
        end
        u_link.dev_pulse(UTSF_EV_IN, 4'h2);
        idle();
        rd_reg(UTSF_STATUS_OFF);
        check("device event in host role", rd, UTSF_ZERO_RST);
        // both causes stay pending: device pushes earlier, host events now
        rd_reg(UTSF_IRQSTAT_OFF);
        check("irq causes", rd, 32'h0000_0003);
        wrapUp();
    end
endmodule
